// >>> hdl/thread_load_pkg.sv
// constants, register map and state encoding of the thread/load sequencer
package thread_load_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  // control register fields
  localparam int CTRL_LEVEL_BIT = 0;  // 1 = later engineering level
  localparam int CTRL_CLEAR_BIT = 1;  // write 1: operator clear
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // status register fields
  localparam int ST_THREAD_BIT  = 4;
  localparam int ST_CHECK_BIT   = 5;
  localparam int ST_PERM_BIT    = 6;
  localparam int ST_UNLOAD_BIT  = 7;
  localparam int ST_RETRY_BIT   = 8;
  localparam int ST_MOTOR_BIT   = 9;
  localparam int ST_MECHOK_BIT  = 10;
  localparam int ST_COUNT_LSB   = 16;
  // gap-pulse checkpoints
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CP_TAPE      = 6'd7;
  localparam logic [CNT_W-1:0] CP_HUB       = 6'd12;
  localparam logic [CNT_W-1:0] CP_HUB_OLD   = 6'd9;
  localparam logic [CNT_W-1:0] CP_RETRY     = 6'd20;
  localparam logic [CNT_W-1:0] CP_HUB2      = 6'd28;
  localparam logic [CNT_W-1:0] CP_START     = 6'd44;
  localparam logic [CNT_W-1:0] CP_START_OLD = 6'd36;
  localparam logic [CNT_W-1:0] CP_COLUMN    = 6'd4;
  // synchronised input positions
  localparam int IN_PULSE = 0;
  localparam int IN_BTN   = 1;
  localparam int IN_RST   = 2;
  localparam int IN_CART  = 3;
  localparam int IN_TAPE  = 4;
  localparam int IN_HUB   = 5;
  localparam int IN_START = 6;
  localparam int IN_LVAC  = 7;
  localparam int IN_LBOT  = 8;
  localparam int IN_RBOT  = 9;
  localparam int IN_DOOR  = 10;
  localparam int IN_BAIL  = 11;
  localparam int IN_LAMP  = 12;
  localparam int IN_BOTM  = 13;
  localparam int IN_AIR   = 14;
  localparam int IN_OPEN  = 15;
  localparam int NIN      = 16;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_ATT1   = 4'b0001,
    ST_REW1   = 4'b0011,
    ST_ATT2   = 4'b0010,
    ST_WSTART = 4'b0110,
    ST_COLCHK = 4'b0111,
    ST_DONE   = 4'b0101,
    ST_STOP   = 4'b0100,
    ST_ABORT  = 4'b1100
  } seq_state_t;
endpackage : thread_load_pkg

// >>> hdl/thread_load_check_sequencer.sv
// thread-and-load check sequencer with APB control and status registers
`timescale 1ns/10ps
`default_nettype none
module thread_load_check_sequencer
  import thread_load_pkg::*;
(
  input  wire logic        clk,           // 25 MHz logic clock
  input  wire logic        rst_n,         // synchronous reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb write
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error on unmapped address
  input  wire logic        radiusPulse,   // left reel half-turn photocell
  input  wire logic        loadRewindBtn, // load/rewind pushbutton
  input  wire logic        resetBtn,      // reset pushbutton
  input  wire logic        cartPresent,   // cartridge on right hub
  input  wire logic        tapePresent,   // tape_start/tape_end_marker cells
  input  wire logic        hubWrapSw,     // hub-wrap switch transferred
  input  wire logic        tapeStartMark, // tape_start_marker sensed
  input  wire logic        leftColVacSw,  // left_column_vacuum_switch
  input  wire logic        leftColBottom, // left column tape bottomed
  input  wire logic        rightColBottom,// right column tape bottomed
  input  wire logic        doorOpen,      // door interlock open
  input  wire logic        safetyBail,    // safety bail tripped
  input  wire logic        lampOff,       // lamp-off condition
  input  wire logic        tapeBottomed,  // tape-bottomed condition
  input  wire logic        airFail,       // air pressure failure
  input  wire logic        cartOpenSw,    // cartridge-open switch transferred
  output logic             threadLatch,   // thread_sequence_latch
  output logic             cartMotor,     // cartridge opening motor drive
  output logic             reelForward,   // reels thread clockwise
  output logic             reelRewind,    // rewind onto file reel
  output logic             unloadLatch,   // both reels unload
  output logic             loadCheck,     // failure latch / lamp
  output logic             permFail,      // permanent failure flag
  output logic             rewindOutOp,   // rewind_out_operation output, driven constant 0
  output logic             mechOk         // mechanical-ok
);

  logic [NIN-1:0]   syncA_reg, syncB_reg, prevB_reg;
  logic [NIN-1:0]   rawIn, rise;
  seq_state_t       state_reg;
  logic [CNT_W-1:0] cnt_reg, cntInc;
  logic             tapeSeen_reg, retryUsed_reg, hubSeen_reg;
  logic             levelNew_reg, opClear;
  logic             pulse, permit, operator, startBtn;
  logic [CNT_W-1:0] hubLimit, startLimit;
  logic             setupRd;

  assign rawIn = {cartOpenSw, airFail, tapeBottomed, lampOff, safetyBail,
                  doorOpen, rightColBottom, leftColBottom, leftColVacSw,
                  tapeStartMark, hubWrapSw, tapePresent, cartPresent,
                  resetBtn, loadRewindBtn, radiusPulse};

  // two-stage synchroniser; only stage B feeds logic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      prevB_reg <= '0;
    end else begin
      syncA_reg <= rawIn;
      syncB_reg <= syncA_reg;
      prevB_reg <= syncB_reg;
    end
  end
  assign rise = syncB_reg & ~prevB_reg;

  assign pulse    = rise[IN_PULSE];
  assign cntInc   = cnt_reg + 6'd1;
  assign operator = rise[IN_RST] | opClear;
  assign startBtn = rise[IN_BTN];
  assign hubLimit   = levelNew_reg ? CP_HUB : CP_HUB_OLD;
  assign startLimit = levelNew_reg ? CP_START : CP_START_OLD;
  assign permit = !(syncB_reg[IN_DOOR] | syncB_reg[IN_LBOT] |
                    syncB_reg[IN_RBOT] | syncB_reg[IN_RST] |
                    syncB_reg[IN_BAIL] | !mechOk);

  always_ff @(posedge clk) begin
    if (!rst_n)
      mechOk <= 1'b0;
    else
      mechOk <= !(syncB_reg[IN_LAMP] | syncB_reg[IN_BOTM] |
                  syncB_reg[IN_AIR]);
  end

  // sequence state and gap counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= '0;
      tapeSeen_reg  <= 1'b0;
      hubSeen_reg   <= 1'b0;
      retryUsed_reg <= 1'b0;
      threadLatch   <= 1'b0;
      loadCheck     <= 1'b0;
      permFail      <= 1'b0;
      unloadLatch   <= 1'b0;
    end else if (operator) begin
      // only the operator releases a stopped or failed sequence
      state_reg     <= ST_IDLE;
      cnt_reg       <= '0;
      tapeSeen_reg  <= 1'b0;
      hubSeen_reg   <= 1'b0;
      retryUsed_reg <= 1'b0;
      threadLatch   <= 1'b0;
      loadCheck     <= 1'b0;
      permFail      <= 1'b0;
      unloadLatch   <= 1'b0;
    end else begin
      if (pulse && state_reg != ST_IDLE)
        cnt_reg <= cntInc;
      case (state_reg)
        ST_IDLE: begin
          if (startBtn && permit) begin
            threadLatch  <= 1'b1;
            cnt_reg      <= '0;
            tapeSeen_reg <= 1'b0;
            state_reg    <= ST_ATT1;
          end
        end
        ST_ATT1: begin
          if (syncB_reg[IN_TAPE])
            tapeSeen_reg <= 1'b1;
          if (syncB_reg[IN_CART]) begin
            if (pulse && cntInc == CP_TAPE && !tapeSeen_reg) begin
              loadCheck   <= 1'b1;
              unloadLatch <= 1'b1;
              state_reg   <= ST_REW1;
            end else if (pulse && cntInc == CP_HUB) begin
              if (syncB_reg[IN_HUB]) begin
                state_reg <= ST_WSTART;
              end else begin
                loadCheck   <= 1'b1;
                unloadLatch <= 1'b1;
                state_reg   <= ST_REW1;
              end
            end
          end else if (pulse && cntInc == hubLimit) begin
            if (syncB_reg[IN_HUB]) begin
              state_reg <= ST_WSTART;
            end else begin
              loadCheck   <= 1'b1;
              unloadLatch <= 1'b1;
              threadLatch <= 1'b0;
              state_reg   <= ST_STOP;
            end
          end
        end
        ST_REW1: begin
          if (pulse && cntInc == CP_RETRY) begin
            retryUsed_reg <= 1'b1;
            unloadLatch   <= 1'b0;
            hubSeen_reg   <= 1'b0;
            state_reg     <= ST_ATT2;
          end
        end
        ST_ATT2: begin
          if (syncB_reg[IN_HUB])
            hubSeen_reg <= 1'b1;
          if (pulse && cntInc == CP_HUB2) begin
            if (hubSeen_reg || syncB_reg[IN_HUB]) begin
              state_reg <= ST_WSTART;
            end else begin
              permFail    <= 1'b1;
              unloadLatch <= 1'b1;
              threadLatch <= 1'b0;
              state_reg   <= ST_ABORT;
            end
          end
        end
        ST_WSTART: begin
          if (rise[IN_START]) begin
            cnt_reg   <= '0;
            state_reg <= ST_COLCHK;
          end else if (pulse && cntInc == startLimit) begin
            loadCheck   <= 1'b1;
            threadLatch <= 1'b0;
            state_reg   <= ST_STOP;
          end
        end
        ST_COLCHK: begin
          if (pulse && cntInc == CP_COLUMN) begin
            threadLatch <= 1'b0;
            if (syncB_reg[IN_LVAC]) begin
              state_reg <= ST_DONE;
            end else begin
              loadCheck <= 1'b1;
              state_reg <= ST_STOP;
            end
          end
        end
        ST_DONE, ST_STOP, ST_ABORT: cnt_reg <= cnt_reg;
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // with a cartridge present, motor runs from latch set until the opener reports fully open or the operator clears
  always_ff @(posedge clk) begin
    if (!rst_n)
      cartMotor <= 1'b0;
    else if (!syncB_reg[IN_CART] || syncB_reg[IN_OPEN] || operator)
      cartMotor <= 1'b0;
    else if (state_reg == ST_IDLE && startBtn && permit)
      cartMotor <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reelForward <= 1'b0;
      reelRewind  <= 1'b0;
      rewindOutOp <= 1'b0;
    end else begin
      reelForward <= threadLatch &&
                     (state_reg == ST_ATT1 || state_reg == ST_ATT2 ||
                      state_reg == ST_WSTART || state_reg == ST_COLCHK);
      reelRewind  <= (state_reg == ST_REW1 ||
                      state_reg == ST_ABORT);
      rewindOutOp <= 1'b0;
    end
  end

  // apb slave: zero wait states, read data captured in the setup cycle
  assign pready  = 1'b1;
  assign setupRd = psel && !penable && !pwrite;
  assign opClear = psel && penable && pwrite && paddr == CTRL_OFS &&
                   pwdata[CTRL_CLEAR_BIT];
  always_ff @(posedge clk) begin
    if (!rst_n)
      levelNew_reg <= CTRL_RESET[CTRL_LEVEL_BIT];
    else if (psel && penable && pwrite && paddr == CTRL_OFS)
      levelNew_reg <= pwdata[CTRL_LEVEL_BIT];
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= '0;
      pslverr <= !(paddr == CTRL_OFS || paddr == STATUS_OFS);
      if (setupRd && paddr == CTRL_OFS)
        prdata[CTRL_LEVEL_BIT] <= levelNew_reg;
      else if (setupRd && paddr == STATUS_OFS) begin
        prdata[3:0]            <= state_reg;
        prdata[ST_THREAD_BIT]  <= threadLatch;
        prdata[ST_CHECK_BIT]   <= loadCheck;
        prdata[ST_PERM_BIT]    <= permFail;
        prdata[ST_UNLOAD_BIT]  <= unloadLatch;
        prdata[ST_RETRY_BIT]   <= retryUsed_reg;
        prdata[ST_MOTOR_BIT]   <= cartMotor;
        prdata[ST_MECHOK_BIT]  <= mechOk;
        prdata[ST_COUNT_LSB +: CNT_W] <= cnt_reg;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_hit(logic [CNT_W-1:0] n);
    pulse && cntInc == n;
  endsequence
  sequence s_fail1;
    state_reg == ST_ATT1 && syncB_reg[IN_CART] && !operator;
  endsequence

  property p_retry_once;
    $rose(permFail) |-> retryUsed_reg;
  endproperty
  a_retry_once: assert property (p_retry_once)
    else $error("permanent failure without a retry");

  property p_tape7;
    s_fail1 ##0 s_hit(CP_TAPE) ##0 !tapeSeen_reg |=>
      state_reg == ST_REW1 ##1 reelRewind && loadCheck;
  endproperty
  a_tape7: assert property (p_tape7)
    else $error("missing tape at count 7 not failed");

  property p_hub12;
    s_fail1 ##0 tapeSeen_reg ##0 s_hit(CP_HUB) ##0 !syncB_reg[IN_HUB]
      |=> state_reg == ST_REW1 && unloadLatch;
  endproperty
  a_hub12: assert property (p_hub12)
    else $error("hub wrap missing at count 12 not failed");

  property p_retry20;
    state_reg == ST_REW1 && !operator ##0 s_hit(CP_RETRY)
      |=> state_reg == ST_ATT2 && cnt_reg == CP_RETRY;
  endproperty
  a_retry20: assert property (p_retry20)
    else $error("second attempt not started at count 20");

  property p_abort28;
    state_reg == ST_ATT2 && !operator && !hubSeen_reg &&
      !syncB_reg[IN_HUB] ##0 s_hit(CP_HUB2)
      |=> permFail ##1 reelRewind && loadCheck;
  endproperty
  a_abort28: assert property (p_abort28)
    else $error("second attempt failure not aborted");

  property p_marker;
    state_reg == ST_WSTART && !operator && !rise[IN_START]
      ##0 s_hit(startLimit) |=> state_reg == ST_STOP && !unloadLatch;
  endproperty
  a_marker: assert property (p_marker)
    else $error("start marker timeout not stopped");

  property p_column;
    state_reg == ST_COLCHK && !operator && !syncB_reg[IN_LVAC]
      ##0 s_hit(CP_COLUMN) |=> state_reg == ST_STOP && loadCheck;
  endproperty
  a_column: assert property (p_column)
    else $error("column vacuum failure not stopped");

  property p_no_motor;
    !syncB_reg[IN_CART] |=> !cartMotor;
  endproperty
  a_no_motor: assert property (p_no_motor)
    else $error("cartridge motor on without cartridge");

  property p_permit;
    $rose(threadLatch) |-> $past(permit);
  endproperty
  a_permit: assert property (p_permit)
    else $error("thread latch set while blocked");

  property p_fail_latches;
    $rose(unloadLatch) |-> loadCheck || permFail ##0 !rewindOutOp;
  endproperty
  a_fail_latches: assert property (p_fail_latches)
    else $error("unload without failure latch");

  property p_marker_clear;
    state_reg == ST_WSTART && !operator && rise[IN_START] |=> cnt_reg == '0;
  endproperty
  a_marker_clear: assert property (p_marker_clear)
    else $error("start marker did not clear counter");

endmodule : thread_load_check_sequencer
`default_nettype wire

// >>> verif/thread_drive_model.sv
// behavioural tape drive: reel photocell, threading sensors, cartridge opener
`timescale 1ns/10ps
`default_nettype none
module thread_drive_model (
  input  wire logic       clk,           // bench clock
  input  wire logic       rst_n,         // synchronous reset, active low
  input  wire logic       restart,       // new threading attempt
  input  wire logic [7:0] tapeAt,        // half turns until tape seen, 0 never
  input  wire logic [7:0] hubAt,         // half turns until hub wraps, 0 never
  input  wire logic [7:0] markAt,        // half turn carrying the marker
  input  wire logic       vacOk,         // column vacuum will transfer
  input  wire logic       reelForward,   // reels thread clockwise
  input  wire logic       reelRewind,    // rewind onto file reel
  input  wire logic       cartMotor,     // opener motor drive
  output logic            radiusPulse,   // half-turn photocell
  output logic            tapePresent,   // tape photocells
  output logic            hubWrapSw,     // hub-wrap switch
  output logic            tapeStartMark, // start marker photocell
  output logic            leftColVacSw,  // left column vacuum switch
  output logic            cartOpenSw     // opener fully open
);
  logic [2:0] phase;
  logic [7:0] turns;
  logic [4:0] openCnt;
  logic       opened;
  // sensors move on each falling photocell edge, half a period after the counted rise, so a level never
  // races the checkpoint pulse it is judged against
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      phase <= 3'd0;
      turns <= 8'd0;
    end else if (reelForward || reelRewind) begin
      phase <= phase + 3'd1;
      if (phase == 3'd7)
        turns <= turns + 8'd1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      openCnt <= 5'd0;
      opened  <= 1'b0;
    end else if (cartMotor && !opened) begin
      openCnt <= openCnt + 5'd1;
      opened  <= (openCnt == 5'd19);
    end
  end
  assign radiusPulse   = phase[2];
  assign tapePresent   = (tapeAt != 8'd0) && (turns >= tapeAt);
  assign hubWrapSw     = (hubAt != 8'd0) && (turns >= hubAt);
  assign tapeStartMark = (markAt != 8'd0) && (turns == markAt);
  assign leftColVacSw  = vacOk && (markAt != 8'd0) && (turns >= markAt + 8'd2);
  assign cartOpenSw    = opened;
endmodule // thread_drive_model
`default_nettype wire

// >>> verif/thread_load_check_sequencer_bench.sv
// self-checking bench of the thread/load check sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %0t %s", $time, m); end end
module thread_load_check_sequencer_bench;
  import thread_load_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdq, rs;
  logic        rde, radiusPulse, loadRewindBtn, resetBtn, cartPresent;
  logic        tapePresent, hubWrapSw, tapeStartMark, leftColVacSw;
  logic        doorOpen, leftColBottom, rightColBottom, safetyBail, lampOff;
  logic        tapeBottomed, airFail, cartOpenSw, threadLatch, cartMotor;
  logic        reelForward, reelRewind, unloadLatch, loadCheck, permFail;
  logic        rewindOutOp, mechOk, restart, vacOk;
  logic [7:0]  tapeAt, hubAt, markAt, block;
  int          err_total, n_checks, cyc, caseNo;
  assign {airFail, tapeBottomed, lampOff, safetyBail, rightColBottom,
          leftColBottom, doorOpen} = block[6:0];
  thread_load_check_sequencer uut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .radiusPulse(radiusPulse), .loadRewindBtn(loadRewindBtn),
    .resetBtn(resetBtn), .cartPresent(cartPresent),
    .tapePresent(tapePresent), .hubWrapSw(hubWrapSw),
    .tapeStartMark(tapeStartMark), .leftColVacSw(leftColVacSw),
    .leftColBottom(leftColBottom), .rightColBottom(rightColBottom),
    .doorOpen(doorOpen), .safetyBail(safetyBail), .lampOff(lampOff),
    .tapeBottomed(tapeBottomed), .airFail(airFail), .cartOpenSw(cartOpenSw),
    .threadLatch(threadLatch), .cartMotor(cartMotor),
    .reelForward(reelForward), .reelRewind(reelRewind),
    .unloadLatch(unloadLatch), .loadCheck(loadCheck), .permFail(permFail),
    .rewindOutOp(rewindOutOp), .mechOk(mechOk));
  thread_drive_model drive (.clk(clk), .rst_n(rst_n), .restart(restart),
    .tapeAt(tapeAt), .hubAt(hubAt), .markAt(markAt), .vacOk(vacOk),
    .reelForward(reelForward), .reelRewind(reelRewind),
    .cartMotor(cartMotor), .radiusPulse(radiusPulse),
    .tapePresent(tapePresent), .hubWrapSw(hubWrapSw),
    .tapeStartMark(tapeStartMark), .leftColVacSw(leftColVacSw),
    .cartOpenSw(cartOpenSw));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic tally_and_finish;
    if (err_total == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      $display("MISMATCH %0t run did not finish", $time);
      tally_and_finish();
    end
  end
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // state, loadCheck, permFail, unloadLatch, retry used
  function automatic logic [7:0] expect_end(input logic c, lv,
      input int t, h, m, input logic v);
    logic rt;
    rt = c && (t == 0 || t >= 7 || h == 0 || h >= 12);
    if (rt && (h == 0 || h >= 28))
      return {ST_ABORT, 4'b1111};
    if (!c && (h == 0 || h >= (lv ? 12 : 9)))
      return {ST_STOP, 4'b1010};
    if (m == 0 || m >= (lv ? 44 : 36) || !v)
      return {ST_STOP, 3'b100, rt};
    return {ST_DONE, rt, 2'b00, rt};
  endfunction
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no wait limit here: only the bench timeout ends a stuck transfer
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdq = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic press;
    loadRewindBtn <= 1'b1;
    repeat (6) @(posedge clk);
    loadRewindBtn <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic run_case(input logic c, lv, input int t, h, m,
      input logic v);
    logic [7:0] ex;
    logic       seen;
    ex = expect_end(c, lv, t, h, m, v);
    seen = 1'b0;
    caseNo++;
    // alternate the two operator clear paths
    apb(1'b1, CTRL_OFS, {30'd0, caseNo[0], lv});
    if (!caseNo[0]) begin
      resetBtn <= 1'b1;
      repeat (6) @(posedge clk);
      resetBtn <= 1'b0;
    end
    cartPresent <= c;
    tapeAt <= 8'(t);
    hubAt <= 8'(h);
    markAt <= 8'(m);
    vacOk <= v;
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK({loadCheck, permFail, unloadLatch}, 3'b000, "not cleared")
    press();
    `CHK({threadLatch, reelForward}, 2'b11, "thread latch not set")
    `CHK(cartMotor, c, "cartridge motor wrong")
    for (int k = 0; k < 1500; k++) begin
      apb(1'b0, STATUS_OFS, 32'h0000_0000);
      `CHK(cartMotor & ~c, 1'b0, "motor without cartridge")
      if (rdq[3:0] == ST_REW1 && !seen) begin
        seen = 1'b1;
        `CHK({reelRewind, unloadLatch}, 2'b11, "no rewind on fail")
      end
      if (rdq[3:0] inside {ST_DONE, ST_STOP, ST_ABORT})
        break;
    end
    `CHK(rdq[3:0], ex[7:4], "end state")
    `CHK(rdq[ST_RETRY_BIT], ex[0], "retry flag")
    `CHK({loadCheck, permFail, unloadLatch}, ex[3:1], "latches")
    `CHK({rewindOutOp, threadLatch, cartMotor}, 3'b000, "outputs")
    if (ex[7:4] == ST_ABORT) begin
      `CHK(reelRewind, 1'b1, "abort without rewind")
      press();
      `CHK(permFail, 1'b1, "failure flag lost")
    end
    if (ex[7:4] == ST_STOP && !ex[1])
      `CHK(reelRewind, 1'b0, "rewind on marker stop")
  endtask
  initial begin
    logic [31:0] r;
    logic        c, lv, v, rt;
    int          t, h, m, en;
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {loadRewindBtn, resetBtn, cartPresent, restart, vacOk} = '0;
    {tapeAt, hubAt, markAt, block} = '0;
    err_total = 0;
    n_checks = 0;
    cyc = 0;
    caseNo = 0;
    rs = 32'h0000_005A;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK({mechOk, threadLatch}, 2'b10, "after reset")
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    `CHK({rde, rdq}, {1'b0, CTRL_RESET}, "control reset value")
    apb(1'b1, 12'h008, 32'hFFFF_FFFF);
    `CHK(rde, 1'b1, "unmapped write accepted")
    apb(1'b0, 12'h008, 32'h0000_0000);
    `CHK({rde, rdq}, {1'b1, 32'h0000_0000}, "unmapped read")
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    `CHK(rdq, 32'h0000_0000, "level bit")
    cartPresent <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i == 7)
        resetBtn <= 1'b1;
      else
        block <= 8'h01 << i;
      repeat (6) @(posedge clk);
      `CHK(mechOk, (i < 4 || i == 7), "mechanical ok")
      press();
      `CHK({threadLatch, cartMotor}, 2'b00, "blocked load")
      block <= 8'h00;
      resetBtn <= 1'b0;
      repeat (6) @(posedge clk);
    end
    run_case(1, 1, 3, 10, 20, 1);
    run_case(1, 1, 6, 11, 43, 1);
    run_case(1, 1, 7, 10, 30, 1);
    run_case(1, 1, 3, 12, 30, 1);
    run_case(1, 1, 0, 0, 0, 1);
    run_case(1, 1, 3, 28, 35, 1);
    run_case(1, 1, 0, 27, 35, 1);
    run_case(1, 0, 3, 10, 36, 1);
    run_case(1, 0, 3, 10, 35, 1);
    run_case(1, 1, 3, 10, 44, 1);
    run_case(1, 1, 3, 10, 30, 0);
    run_case(0, 1, 0, 11, 20, 1);
    run_case(0, 1, 0, 12, 20, 1);
    run_case(0, 0, 0, 9, 20, 1);
    run_case(0, 0, 0, 8, 20, 1);
    for (int i = 0; i < 10; i++) begin
      r = xs();
      c = r[0];
      lv = r[1];
      v = |r[3:2];
      t = (r[6:4] == 0) ? 0 : 1 + r[11:8] % 9;
      h = (r[14:12] == 0) ? 0 : 2 + r[19:15] % 30;
      rt = c && (t == 0 || t >= 7 || h == 0 || h >= 12);
      // a retried load only starts watching for the marker at count 28
      en = !c ? (lv ? 12 : 9) : rt ? 28 : 12;
      m = (r[22:20] == 0) ? 0 : en + 2 + r[29:24] % 34;
      run_case(c, lv, t, h, m, v);
    end
    tally_and_finish();
  end
endmodule // thread_load_check_sequencer_bench
`default_nettype wire
